// [design/flash_port_pkg.sv]
package flash_port_pkg;

  // ----------------------------------------------------------------
  // Array and timing
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int ARRAY_DEPTH = 4096;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
  localparam int POLL_BIT = 7;

  localparam int CLK_PERIOD_NS = 8;
  localparam int WRITE_TIME_NS = 1500000;
  localparam int ERASE_TIME_NS = 10000000;
  // Longest time rounds down, least time rounds up
  localparam int WRITE_CYCLES_DFLT = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES_DFLT =
    (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;

  // ----------------------------------------------------------------
  // Signature
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SIG_ADDR_MAKER = 12'h030;
  localparam logic [ADDR_W-1:0] SIG_ADDR_PART = 12'h031;
  localparam logic [ADDR_W-1:0] SIG_ADDR_VOLT = 12'h032;
  // Arbitrary identity values
  localparam logic [DATA_W-1:0] SIG_MAKER_DFLT = 8'h3c;
  localparam logic [DATA_W-1:0] SIG_PART_DFLT = 8'h7a;
  localparam logic [DATA_W-1:0] SIG_VOLT_LOW = 8'h05;
  localparam logic [DATA_W-1:0] SIG_VOLT_HIGH = 8'hff;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;
  localparam int CTRL_LOW_VOLT_BIT = 0;
  localparam logic CTRL_LOW_VOLT_RST = 1'b0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERASING_BIT = 1;
  localparam int STAT_STRAP_BIT = 2;
  localparam int STAT_REFUSED_BIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rst_pin;
    logic store_read_strobe_n;
    logic addr_latch_prog_strobe;
    logic ext_access_prog_enable;
    logic ext_access_strap;
    logic mode_select_a;
    logic mode_select_b;
    logic mode_select_c;
    logic mode_select_d;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } prog_pins_t;

  localparam int PINS_W = $bits(prog_pins_t);

  typedef struct packed {
    logic table_read_block;
    logic strap_latched_mode;
    logic prog_disable;
    logic verify_disable;
    logic ext_exec_disable;
  } protect_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_WRITE, OP_READ, OP_LOCK1, OP_LOCK2, OP_LOCK3, OP_ERASE,
    OP_SIG
  } op_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_STROBE = 5'b00010,
    ST_WRITE = 5'b00100,
    ST_HOLD = 5'b01000,
    ST_ERASE = 5'b10000
  } state_t;

endpackage

// [design/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  // First stage feeds only the second
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage_one <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule
`default_nettype wire

// [design/flash_program_port.sv]
// Overview of operation
// - One low strobe pulse starts one self-timed byte or lock write.
// - During a write, reading last byte returns bit 7 complemented.
// - Polling reads allowed any time, never disturbing the write.
// - Ready/busy goes low once the strobe rises in programming.
// - Ready/busy returns high when self-timed programming finishes.
// - Erase selects with strobe held low 10 ms clears the array.
// - After chip erase every location reads all ones.
// - Array starts in erased state, every byte reading FFH.
// - Code read-back only while lock bits one and two are not both programmed.
// - No direct read-back path exists for the lock bits.
// - Lock one blocks table reads, latches strap, refuses programming.
// - Locks one and two add disabling of verify reads.
// - All three locks add disabling of external execution.
// - With lock one, strap sampled during reset and held until next.
// - Strap latch reads 0 until a reset samples it; must match live level.
// - Signature read at 030H..032H with all four selects A, B, C, D low.
// - Data port takes code bytes in, drives verify bytes out.
`timescale 1ns/1ps
`default_nettype none
module flash_program_port #(
  parameter int WRITE_CYCLES = flash_port_pkg::WRITE_CYCLES_DFLT,
  parameter int ERASE_CYCLES = flash_port_pkg::ERASE_CYCLES_DFLT,
  parameter logic [7:0] SIG_MAKER = flash_port_pkg::SIG_MAKER_DFLT,
  parameter logic [7:0] SIG_PART = flash_port_pkg::SIG_PART_DFLT
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Programming pins
  input wire flash_port_pkg::prog_pins_t pins,
  output logic [flash_port_pkg::DATA_W-1:0] data_out,
  output logic data_oe_n,
  output logic ready_busy_out,
  // Protection to the core
  output flash_port_pkg::protect_t protect,
  output logic ext_access_effective,
  // AXI4-Lite slave
  input wire logic [flash_port_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [flash_port_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import flash_port_pkg::*;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // mode decode
  function automatic op_t decode_op(input prog_pins_t p);
    logic [3:0] sel;
    sel = {p.mode_select_a, p.mode_select_b, p.mode_select_c,
           p.mode_select_d};
    decode_op = OP_NONE;
    if (p.rst_pin && !p.store_read_strobe_n) begin
      unique case (sel)
        4'h7: decode_op = OP_WRITE;
        4'h3: decode_op = OP_READ;
        4'hf: decode_op = OP_LOCK1;
        4'hc: decode_op = OP_LOCK2;
        4'ha: decode_op = OP_LOCK3;
        4'h8: decode_op = OP_ERASE;
        4'h0: decode_op = OP_SIG;
        default: decode_op = OP_NONE;
      endcase
    end
  endfunction

  function automatic logic is_reg(input logic [AXI_AW-1:0] a);
    is_reg = (a == REG_CTRL) || (a == REG_STATUS);
  endfunction

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] array_mem [ARRAY_DEPTH];
  prog_pins_t sp;
  op_t cur_op;
  state_t state;
  logic [CNT_W-1:0] cnt;
  logic [ADDR_W-1:0] walk;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  op_t wr_op;
  logic lock_bit_one;
  logic lock_bit_two;
  logic lock_bit_three;
  logic strap_latch;
  logic low_volt_part;
  logic refused;
  logic prog_ok;
  logic busy;
  logic commit;
  logic erase_done;
  logic [DATA_W-1:0] sig_byte;
  logic [AXI_AW-1:0] aw_addr;
  logic aw_held;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  initial begin
    for (int i = 0; i < ARRAY_DEPTH; i++) begin
      array_mem[i] = ERASED_BYTE;
    end
  end

  pin_sync #(.WIDTH(PINS_W)) u_pin_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in(pins),
    .sync_out(sp)
  );

  assign cur_op = decode_op(sp);
  assign busy = (state == ST_WRITE) || (state == ST_ERASE);
  assign commit = (state == ST_WRITE) &&
                  (cnt == CNT_W'(WRITE_CYCLES - 1));
  assign erase_done = (state == ST_ERASE) &&
                      (walk == ADDR_W'(ARRAY_DEPTH - 1));
  // lock one refuses code writes; lock bits stay writable
  assign prog_ok = sp.ext_access_prog_enable &&
                   !(wr_op == OP_WRITE && lock_bit_one);

  // ----------------------------------------------------------------
  // Programming sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      cnt <= '0;
      walk <= '0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_op <= OP_NONE;
      refused <= 1'b0;
    end else if (clk_en) begin
      unique case (state)
        ST_IDLE: begin
          cnt <= '0;
          if (!sp.addr_latch_prog_strobe) begin
            if (cur_op == OP_ERASE) begin
              state <= ST_HOLD;
            end else if (cur_op == OP_WRITE || cur_op == OP_LOCK1 ||
                         cur_op == OP_LOCK2 || cur_op == OP_LOCK3) begin
              state <= ST_STROBE;
              wr_addr <= sp.addr;
              wr_data <= sp.data;
              wr_op <= cur_op;
            end
          end
        end
        ST_STROBE: begin
          if (sp.addr_latch_prog_strobe) begin
            state <= prog_ok ? ST_WRITE : ST_IDLE;
            refused <= !prog_ok;
          end
        end
        ST_WRITE: begin
          cnt <= cnt + CNT_W'(1);
          if (commit) begin
            state <= ST_IDLE;
          end
        end
        ST_HOLD: begin
          // strobe must stay low long enough
          cnt <= cnt + CNT_W'(1);
          if (sp.addr_latch_prog_strobe || cur_op != OP_ERASE) begin
            state <= ST_IDLE;
          end else if (cnt == CNT_W'(ERASE_CYCLES - 1)) begin
            state <= ST_ERASE;
            walk <= '0;
          end
        end
        ST_ERASE: begin
          walk <= walk + ADDR_W'(1);
          if (erase_done) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Array writes
  // ----------------------------------------------------------------
  // Erase walks one byte a cycle after the hold time
  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      if (state == ST_ERASE) begin
        array_mem[walk] <= ERASED_BYTE;
      end else if (commit && wr_op == OP_WRITE) begin
        array_mem[wr_addr] <= wr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Lock bits and strap latch
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_bit_one <= 1'b0;
      lock_bit_two <= 1'b0;
      lock_bit_three <= 1'b0;
    end else if (clk_en) begin
      if (erase_done) begin
        lock_bit_one <= 1'b0;
        lock_bit_two <= 1'b0;
        lock_bit_three <= 1'b0;
      end else if (commit) begin
        lock_bit_one <= lock_bit_one || (wr_op == OP_LOCK1);
        lock_bit_two <= lock_bit_two || (wr_op == OP_LOCK2);
        lock_bit_three <= lock_bit_three || (wr_op == OP_LOCK3);
      end
    end
  end

  // latch holds a constant until a device reset samples it
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_latch <= 1'b0;
    end else if (clk_en) begin
      if (sp.rst_pin) begin
        strap_latch <= sp.ext_access_strap;
      end
    end
  end

  assign protect.table_read_block = lock_bit_one;
  assign protect.strap_latched_mode = lock_bit_one;
  assign protect.prog_disable = lock_bit_one;
  // locks one and two stop verify
  assign protect.verify_disable = lock_bit_one && lock_bit_two;
  assign protect.ext_exec_disable = lock_bit_one && lock_bit_two &&
                                    lock_bit_three;
  assign ext_access_effective = lock_bit_one ? strap_latch :
                                sp.ext_access_strap;

  // ----------------------------------------------------------------
  // Verify, poll and signature reads
  // ----------------------------------------------------------------
  // signature bytes
  always_comb begin
    sig_byte = ERASED_BYTE;
    if (sp.addr == SIG_ADDR_MAKER) begin
      sig_byte = SIG_MAKER;
    end else if (sp.addr == SIG_ADDR_PART) begin
      sig_byte = SIG_PART;
    end else if (sp.addr == SIG_ADDR_VOLT) begin
      sig_byte = low_volt_part ? SIG_VOLT_LOW : SIG_VOLT_HIGH;
    end
  end

  // lock bits never reach the data port
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_out <= '0;
      data_oe_n <= 1'b1;
    end else if (clk_en) begin
      data_oe_n <= 1'b1;
      if (sp.addr_latch_prog_strobe && cur_op == OP_SIG) begin
        data_out <= sig_byte;
        data_oe_n <= 1'b0;
      // verify unless locks one and two are both set
      end else if (sp.addr_latch_prog_strobe && cur_op == OP_READ &&
                   !protect.verify_disable) begin
        data_oe_n <= 1'b0;
        if (state == ST_WRITE && wr_op == OP_WRITE && sp.addr == wr_addr)
        begin
          data_out <= wr_data ^ (DATA_W'(1) << POLL_BIT);
        end else begin
          data_out <= array_mem[sp.addr];
        end
      end
    end
  end

  assign ready_busy_out = !busy;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = clk_en && !aw_held && !s_axi_bvalid;
  assign s_axi_wready = clk_en && !w_held && !s_axi_bvalid;
  assign s_axi_arready = clk_en && !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      low_volt_part <= CTRL_LOW_VOLT_RST;
    end else if (clk_en) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_reg(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        if (aw_addr == REG_CTRL && w_strb[0]) begin
          low_volt_part <= w_data[CTRL_LOW_VOLT_BIT];
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= is_reg(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        s_axi_rdata <= '0;
        if (s_axi_araddr == REG_CTRL) begin
          s_axi_rdata[CTRL_LOW_VOLT_BIT] <= low_volt_part;
        end else if (s_axi_araddr == REG_STATUS) begin
          s_axi_rdata[STAT_BUSY_BIT] <= busy;
          s_axi_rdata[STAT_ERASING_BIT] <= (state == ST_ERASE);
          s_axi_rdata[STAT_STRAP_BIT] <= strap_latch;
          s_axi_rdata[STAT_REFUSED_BIT] <= refused;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/flash_port_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_port_checker #(
  parameter int WRITE_CYCLES = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Programming side
  input wire flash_port_pkg::prog_pins_t pins,
  input wire logic data_oe_n,
  input wire logic ready_busy_out,
  input wire flash_port_pkg::protect_t protect,
  input wire logic ext_access_effective,
  // Register read channel
  input wire logic [flash_port_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  import flash_port_pkg::*;
  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  // Erase busy is 4096 cycles, one per byte; the strobe hold is not busy
  localparam int BUSY_MAX = 4200;
  logic [15:0] low_cnt;
  logic [3:0] sel;
  logic prog_on;
  assign sel = {pins.mode_select_a, pins.mode_select_b,
    pins.mode_select_c, pins.mode_select_d};
  assign prog_on = pins.rst_pin && !pins.store_read_strobe_n;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst || ready_busy_out) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= low_cnt + 16'h1;
    end
  end
  sequence s_write_rise;
    $rose(pins.addr_latch_prog_strobe) && prog_on && sel == 4'b0111 &&
      pins.ext_access_prog_enable && ready_busy_out &&
      !protect.prog_disable;
  endsequence
  sequence s_locked_read;
    (prog_on && sel == 4'b0011 && pins.addr_latch_prog_strobe &&
      protect.verify_disable)[*5];
  endsequence
  sequence s_strap_held;
    (protect.strap_latched_mode && !pins.rst_pin)[*4];
  endsequence
  property p_busy_start;
    s_write_rise |-> ##[2:6] !ready_busy_out;
  endproperty
  property p_busy_min;
    $rose(ready_busy_out) |-> low_cnt >= WRITE_CYCLES;
  endproperty
  property p_busy_max;
    low_cnt < BUSY_MAX;
  endproperty
  property p_lock_one;
    protect.table_read_block == protect.prog_disable &&
      protect.strap_latched_mode == protect.prog_disable;
  endproperty
  property p_lock_two;
    protect.verify_disable |-> protect.prog_disable;
  endproperty
  property p_lock_three;
    protect.ext_exec_disable |-> protect.verify_disable;
  endproperty
  property p_verify_off;
    s_locked_read |-> data_oe_n;
  endproperty
  property p_strap;
    s_strap_held |=> $stable(ext_access_effective);
  endproperty
  property p_rd_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr != REG_CTRL &&
      s_axi_araddr != REG_STATUS |=>
      s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy did not follow the write strobe");
  a_busy_min: assert property (p_busy_min)
    else $error("busy ended before the write time");
  a_busy_max: assert property (p_busy_max)
    else $error("busy never returned to ready");
  a_lock_one: assert property (p_lock_one)
    else $error("first lock protections disagree");
  a_lock_two: assert property (p_lock_two)
    else $error("verify lock without program lock");
  a_lock_three: assert property (p_lock_three)
    else $error("execution lock without verify lock");
  a_verify_off: assert property (p_verify_off)
    else $error("locked code byte driven out");
  a_strap: assert property (p_strap)
    else $error("latched strap changed outside reset");
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not refused");
endmodule
bind flash_program_port flash_port_checker #(
  .WRITE_CYCLES(WRITE_CYCLES)
) u_chk (.core_clk, .sys_rst, .pins, .data_oe_n, .ready_busy_out,
  .protect, .ext_access_effective, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp);
`default_nettype wire

// [verification/programmer_model.sv]
`timescale 1ns/1ps
`default_nettype none
module programmer_model (
  // Clock
  input wire logic core_clk,
  // Device pins
  output flash_port_pkg::prog_pins_t pins,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n
);
  import flash_port_pkg::*;
  // -------------------------------------------------------------
  // Pin drive
  // -------------------------------------------------------------
  prog_pins_t p;
  logic drive;
  logic [7:0] wr_byte;
  logic [7:0] port_lvl;
  assign port_lvl = data_oe_n ? 8'hff : data_out;
  assign pins = {p[PINS_W-1:DATA_W], drive ? wr_byte : port_lvl};
  initial begin
    p = '0;
    p.rst_pin = 1'b1;
    p.addr_latch_prog_strobe = 1'b1;
    p.ext_access_prog_enable = 1'b1;
    drive = 1'b0;
    wr_byte = 8'h00;
  end
  task automatic setup(input logic [3:0] m, input logic [11:0] a);
    @(posedge core_clk);
    {p.mode_select_a, p.mode_select_b, p.mode_select_c,
      p.mode_select_d} <= m;
    p.addr <= a;
  endtask
  task automatic pulse(input logic [3:0] m, input logic [11:0] a,
    input logic [7:0] d, input logic en, input int n);
    setup(m, a);
    wr_byte <= d;
    drive <= 1'b1;
    p.ext_access_prog_enable <= en;
    repeat (4) @(posedge core_clk);
    // one low pulse of n cycles
    p.addr_latch_prog_strobe <= 1'b0;
    repeat (n) @(posedge core_clk);
    p.addr_latch_prog_strobe <= 1'b1;
    repeat (4) @(posedge core_clk);
    drive <= 1'b0;
    p.ext_access_prog_enable <= 1'b1;
  endtask
  task automatic read(input logic [3:0] m, input logic [11:0] a,
    output logic [7:0] q, output logic oe_n);
    setup(m, a);
    repeat (6) @(posedge core_clk);
    #1;
    q = port_lvl;
    oe_n = data_oe_n;
  endtask
  task automatic ctl(input logic rst, input logic strap);
    @(posedge core_clk);
    p.rst_pin <= rst;
    p.ext_access_strap <= strap;
    repeat (6) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// [verification/tb_flash_program_port.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_flash_program_port;
  import flash_port_pkg::*;
  // -------------------------------------------------------------
  // Setup
  // -------------------------------------------------------------
  localparam int WR_CYC = 40;
  localparam int ER_CYC = 30;
  localparam logic [3:0] M_WR = 4'b0111;
  localparam logic [3:0] M_RD = 4'b0011;
  localparam logic [3:0] M_ER = 4'b1000;
  localparam logic [3:0] M_SG = 4'b0000;
  localparam logic [3:0] LOCK_M [3] = '{4'b1111, 4'b1100, 4'b1010};
  localparam logic [4:0] PROT_EXP [3] = '{5'h1c, 5'h1e, 5'h1f};
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  prog_pins_t pins;
  logic [7:0] data_out, q;
  logic data_oe_n, ready_busy_out, ext_access_effective, oe_n;
  protect_t protect;
  logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] lfsr = 16'hf41b;
  logic [11:0] wr_addr [6];
  logic [7:0] wr_data [6];
  int bad_count = 0, compares = 0;
  always #4 core_clk = ~core_clk;
  flash_program_port #(.WRITE_CYCLES(WR_CYC), .ERASE_CYCLES(ER_CYC)) DUT (
    .core_clk, .sys_rst, .clk_en(1'b1), .pins, .data_out, .data_oe_n,
    .ready_busy_out, .protect, .ext_access_effective, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  programmer_model prog (.core_clk, .pins, .data_out, .data_oe_n);
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] sig_exp(input int i, input logic low);
    if (i == 0) return SIG_MAKER_DFLT;
    if (i == 1) return SIG_PART_DFLT;
    return low ? SIG_VOLT_LOW : SIG_VOLT_HIGH;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("Compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Sampled at the falling edge, so the decision never races the DUT
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(negedge core_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge core_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
    check(resp, RESP_OKAY);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ar, r;
    r = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r) begin
      @(negedge core_clk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge core_clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
    end
    check(resp, (a == REG_CTRL || a == REG_STATUS) ? RESP_OKAY : RESP_SLVERR);
  endtask
  task automatic wait_ready(input int lim);
    for (int n = 0; n < lim && ready_busy_out !== 1'b1; n++)
      @(posedge core_clk);
    #1;
    check(ready_busy_out, 1'b1);
  endtask
  // -------------------------------------------------------------
  // Tests
  // -------------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    axi_rd(REG_STATUS);
    check(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      prog.read(M_RD, lfsr[11:0], q, oe_n);
      check(q, ERASED_BYTE);
    end
    for (int lv = 0; lv < 2; lv++) begin
      axi_wr(REG_CTRL, lv);
      for (int i = 0; i < 3; i++) begin
        prog.read(M_SG, 12'(SIG_ADDR_MAKER + i), q, oe_n);
        check(q, sig_exp(i, lv[0]));
      end
    end
    axi_rd(REG_CTRL);
    check(rd, 32'h1);
    axi_rd(8'h40);
    check(resp, RESP_SLVERR);
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      wr_addr[i] = {i[2:0], lfsr[8:0]};
      wr_data[i] = lfsr[15:8];
      prog.pulse(M_WR, wr_addr[i], wr_data[i], 1'b1, 3);
      if (i == 0) prog.pulse(M_WR, wr_addr[0] ^ 12'h1, 8'h00, 1'b1, 3);
      prog.read(M_RD, wr_addr[i], q, oe_n);
      check(q, {~wr_data[i][7], wr_data[i][6:0]});
      check(ready_busy_out, 1'b0);
      wait_ready(100);
      prog.read(M_RD, wr_addr[i], q, oe_n);
      check(q, wr_data[i]);
    end
    prog.read(M_RD, wr_addr[0] ^ 12'h1, q, oe_n);
    check(q, ERASED_BYTE);
    prog.pulse(M_WR, 12'hfff, 8'h00, 1'b0, 3);
    axi_rd(REG_STATUS);
    check(rd[STAT_REFUSED_BIT], 1'b1);
    prog.ctl(1'b1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      prog.pulse(LOCK_M[i], 12'h000, 8'h00, 1'b1, 3);
      wait_ready(100);
      check(protect, PROT_EXP[i]);
      prog.read(M_RD, wr_addr[1], q, oe_n);
      check({oe_n, q}, i ? 9'h1ff : {1'b0, wr_data[1]});
    end
    prog.pulse(M_WR, 12'hffe, 8'h00, 1'b1, 3);
    #1 check(ready_busy_out, 1'b1);
    prog.read(M_SG, SIG_ADDR_PART, q, oe_n);
    check(q, SIG_PART_DFLT);
    prog.ctl(1'b0, 1'b1);
    prog.ctl(1'b0, 1'b0);
    check(ext_access_effective, 1'b1);
    prog.ctl(1'b1, 1'b0);
    check(ext_access_effective, 1'b0);
    prog.pulse(M_ER, 12'h000, 8'h00, 1'b1, ER_CYC + 5);
    wait_ready(5000);
    check(protect, 5'h00);
    for (int i = 0; i < 6; i++) begin
      prog.read(M_RD, wr_addr[i], q, oe_n);
      check(q, ERASED_BYTE);
    end
    give_verdict;
  end
  // Whole run needs well under 10000 cycles
  initial begin
    #400000;
    bad_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
